// ### dv/mpg_pin_model.sv
// mpg_pin_model: board side of the gpio bank pads
// assumes pad drive from the bank and board levels from the bench
`timescale 1ns/1ps
module mpg_pin_model
  import mpg_pkg::*;
(
  // clock
  input  wire logic                  ref_clk_in,
  // bank pads and board drive
  input  wire mpg_pad_t [NPORT-1:0]  pad_in,
  input  wire logic [NPORT-1:0][7:0] ext_in,
  input  wire logic [NPORT-1:0][7:0] ext_en_in,
  // resolved levels
  output logic      [NPORT-1:0][7:0] pin_out
);
  logic [NPORT-1:0][7:0] flt_ff;  // wandering level of floating pins

  // floating pins invert every cycle so nothing settles by luck
  always_ff @(posedge ref_clk_in) begin
    flt_ff <= ~pin_out;
  end

  // bank drive wins, then board drive, then pull-up, else floating
  always_comb begin
    for (int l = 0; l < NPORT; l++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_in[l].oe[b]) pin_out[l][b] = pad_in[l].out[b];
        else if (ext_en_in[l][b]) pin_out[l][b] = ext_in[l][b];
        else if (pad_in[l].pu[b]) pin_out[l][b] = 1'b1;
        else pin_out[l][b] = flt_ff[l][b];
      end
    end
  end
endmodule // mpg_pin_model

// ### dv/testbench.sv
// testbench: register-port tests of the gpio bank
// assumes the pin model on the pads and one 250 MHz clock
`timescale 1ns/1ps
module testbench
  import mpg_pkg::*;
;
  logic                  ref_clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  logic [7:0]            addr_in = 8'h00, wdata_in = 8'h00, wmask_in = 8'h00;
  logic                  wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0]            rdata_out;
  logic [NPORT-1:0][7:0] pin_lvl, ext_lvl = '0, ext_en = '1;
  mpg_pad_t [NPORT-1:0]  pad_out;
  mpg_alt_t [NPORT-1:0]  alt_in = '0;  // peripheral outputs kept off
  logic                  tool_conn = 1'b0, two_line = 1'b0;
  logic [7:0]            an_sel, cv_sel;
  logic [2:0]            amp_en, amp_drv;
  logic                  prohib;
  logic                  dbg_din;
  int                    num_errors = 0, compares = 0, cyc = 0;

  // clock and hang limit
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  mpg_gpio_bank dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wmask_in(wmask_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pin_in(pin_lvl), .pad_out(pad_out), .alt_in(alt_in), .dac_en_in(2'h0),
    .tool_conn_in(tool_conn), .dbg_two_line_in(two_line), .dbg_data_out_in(1'b0),
    .dbg_data_oe_in(1'b0), .dbg_clk_in(1'b0), .dbg_data_in_out(dbg_din),
    .analog_sel_out(an_sel), .convert_sel_out(cv_sel), .opamp_en_out(amp_en),
    .opamp_drive_out(amp_drv), .prohibited_out(prohib));

  mpg_pin_model board (.ref_clk_in(ref_clk_in), .pad_in(pad_out), .ext_in(ext_lvl),
    .ext_en_in(ext_en), .pin_out(pin_lvl));

  // one compare, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // single-cycle masked write; settles before returning
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wmask_in <= m;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // read, data taken in the cycle after the strobe
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, exp, rdata_out);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    for (int i = 0; i < NPORT; i++) begin
      rd("dir", OFS_DIR + 8'(i), 8'hFF);
      rd("data", OFS_DATA + 8'(i), 8'h00);
      chk("oe", 8'h00, pad_out[i].oe);
    end
    $display("test reset done");
    wr(8'h0B, 8'h00, 8'hFF);
    wr(8'h03, 8'hA5, 8'hFF);
    chk("p5 oe", 8'hFF, pad_out[3].oe);
    chk("p5 out", 8'hA5, pad_out[3].out);
    wr(8'h03, 8'h00, 8'h01);
    rd("p5 bit", 8'h03, 8'hA4);
    @(posedge ref_clk_in);
    ext_lvl[1] <= 8'h15;
    repeat (3) @(posedge ref_clk_in);
    rd("p3 pins", 8'h01, 8'h15);
    wr(8'h11, 8'h1F, 8'hFF);
    wr(8'h09, 8'hFE, 8'hFF);
    chk("p3 pu", 8'h1E, pad_out[1].pu);
    chk("p3 oe", 8'h01, pad_out[1].oe);
    $display("test port io done");
    wr(8'h04, 8'h02, 8'hFF);  // serial bus unit left stopped
    wr(8'h0C, 8'h00, 8'hFF);
    chk("p6 oe", 8'h01, pad_out[4].oe);
    wr(8'h14, 8'hFF, 8'hFF);
    rd("p6 pu", 8'h14, 8'h00);
    wr(8'h0D, 8'h00, 8'hFF);
    wr(8'h05, 8'h07, 8'hFF);
    wr(OFS_ODSEL, 8'h05, 8'hFF);
    chk("p8 oe", 8'h02, pad_out[5].oe);
    wr(8'h12, 8'h03, 8'hFF);
    chk("p4 pu", 8'h03, pad_out[2].pu);
    wr(8'h16, 8'h01, 8'hFF);
    chk("p10 pu", 8'h01, pad_out[6].pu);
    @(posedge ref_clk_in);
    tool_conn <= 1'b1;
    ext_lvl[2] <= 8'h01;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("p4 tool pu", 8'h00, pad_out[2].pu);
    chk("tool din", 8'h01, {7'h00, dbg_din});
    rd("p4 tool", 8'h02, 8'h00);
    @(posedge ref_clk_in);
    tool_conn <= 1'b0;
    $display("test drive modes done");
    wr(OFS_OPAMP, 8'h01, 8'hFF);
    repeat (2) @(posedge ref_clk_in);
    chk("prohib", 8'h01, {7'h00, prohib});
    wr(OFS_OPAMP, 8'h00, 8'hFF);
    wr(OFS_STAT, 8'h04, 8'h04);
    repeat (2) @(posedge ref_clk_in);
    chk("cleared", 8'h00, {7'h00, prohib});
    wr(OFS_ANCFG, 8'h02, 8'hFF);
    wr(OFS_CHSEL, 8'h01, 8'hFF);
    chk("analog", 8'h02, an_sel);
    chk("convert", 8'h02, cv_sel);
    wr(OFS_OPAMP, 8'h01, 8'hFF);
    chk("amp drv", 8'h01, {5'h00, amp_drv});
    chk("amp en", 8'h01, {5'h00, amp_en});
    chk("convert", 8'h02, cv_sel);
    $display("test analog done");
    wrap_up();
  end
endmodule // testbench

// ### src/mpg_gpio_bank.sv
// mpg_gpio_bank: register file and pad logic of the multi-port gpio bank
// assumes a single-cycle register port, pads resolved outside from out/oe/pu
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module mpg_gpio_bank
  import mpg_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // register port
  input  wire logic [7:0]                 addr_in,
  input  wire logic [7:0]                 wdata_in,
  input  wire logic [7:0]                 wmask_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [7:0]                 rdata_out,
  // pads
  input  wire logic [NPORT-1:0][7:0]      pin_in,
  output mpg_pad_t  [NPORT-1:0]           pad_out,
  // peripheral sharing
  input  wire mpg_alt_t [NPORT-1:0]       alt_in,
  input  wire logic [1:0]                 dac_en_in,
  // debug tool
  input  wire logic                       tool_conn_in,
  input  wire logic                       dbg_two_line_in,
  input  wire logic                       dbg_data_out_in,
  input  wire logic                       dbg_data_oe_in,
  input  wire logic                       dbg_clk_in,
  output logic                            dbg_data_in_out,
  // converter and amplifiers
  output logic      [7:0]                 analog_sel_out,
  output logic      [7:0]                 convert_sel_out,
  output logic      [2:0]                 opamp_en_out,
  output logic      [2:0]                 opamp_drive_out,
  output logic                            prohibited_out
);

  // register state
  logic [NPORT-1:0][7:0] data_ff;
  logic [NPORT-1:0][7:0] dir_ff;
  logic [NPORT-1:0][7:0] pu_ff;
  logic [7:0]            odsel_ff;
  logic [7:0]            ancfg_ff;
  logic [2:0]            opamp_ff;
  logic [2:0]            chsel_ff;
  logic                  badcfg_ff;
  logic [7:0]            rdata_ff;

  // decoded access and lane signals
  mpg_dec_t              wdec;
  mpg_dec_t              rdec;
  logic [NPORT-1:0][7:0] pin_sync;
  logic [NPORT-1:0][7:0] rd_lane;
  logic [NPORT-1:0][7:0] off_lane;
  logic [NPORT-1:0][7:0] pu_blk_lane;
  logic [NPORT-1:0][7:0] od_lane;
  mpg_pad_t [NPORT-1:0]  slice_pad;
  logic [7:0]            opamp_pins;
  logic [7:0]            p2_analog;
  logic                  bad_event;
  logic [7:0]            nxt_rdata;
  logic [7:0]            opamp_wr;
  logic [7:0]            chsel_wr;

  assign wdec = mpg_decode(addr_in);
  assign rdec = mpg_decode(addr_in);

  // masked merge: only bits with a mask bit set change
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] msk);
    return (old & ~msk) | (wd & msk);
  endfunction

  // merged byte for the narrow control registers
  assign opamp_wr = merge({5'h00, opamp_ff}, wdata_in, wmask_in);
  assign chsel_wr = merge({5'h00, chsel_ff}, wdata_in, wmask_in);

  // pad levels cross into the clock domain
  mpg_sync2 #(
    .WIDTH (NPORT*8)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .d_in       (pin_in),
    .q_out      (pin_sync)
  );

  // output latches, cleared by reset
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_ff <= {NPORT{DATA_RST}};
    end else if (wr_in && wdec.kind == KIND_DATA) begin
      for (int i = 0; i < NPORT; i++) begin
        if (wdec.idx == 3'(i)) begin
          data_ff[i] <= merge(data_ff[i], wdata_in, wmask_in) & PIN_MASK[i];
        end
      end
    end
  end

  // direction bits; absent pins stay at 1
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dir_ff <= {NPORT{DIR_RST}};
    end else if (wr_in && wdec.kind == KIND_DIR) begin
      for (int i = 0; i < NPORT; i++) begin
        if (wdec.idx == 3'(i)) begin
          dir_ff[i] <= merge(dir_ff[i], wdata_in, wmask_in) | ~PIN_MASK[i];
        end
      end
    end
  end

  // pull-up selects, only where the port has them
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pu_ff <= {NPORT{PU_RST}};
    end else if (wr_in && wdec.kind == KIND_PU) begin
      for (int i = 0; i < NPORT; i++) begin
        if (wdec.idx == 3'(i)) begin
          pu_ff[i] <= merge(pu_ff[i], wdata_in, wmask_in) & PU_MASK[i];
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_lane
      // per-pin pad logic; dir 0 = output
      mpg_port_slice u_slice (
        .latch_in    (data_ff[gi]),
        .dir_in      (dir_ff[gi]),
        .pu_sel_in   (pu_ff[gi]),
        .od_in       (od_lane[gi]),
        .pin_mask_in (PIN_MASK[gi]),
        .pu_cap_in   (PU_MASK[gi]),
        .off_in      (off_lane[gi]),
        .pu_block_in (pu_blk_lane[gi]),
        .alt_in      (alt_in[gi]),
        .pin_sync_in (pin_sync[gi]),
        .pad_out     (slice_pad[gi]),
        .rd_out      (rd_lane[gi])
      );
    end
  endgenerate

  // open-drain per lane: sixth port always, eighth port by select
  always_comb begin
    od_lane = OD_FORCE;
    od_lane[IDX_P8] = odsel_ff & ODSEL_MASK;
  end

  // analog-shared pins leave digital control; tool pins leave the port
  always_comb begin
    off_lane = '0;
    pu_blk_lane = '0;
    off_lane[IDX_P2] = ancfg_ff;
    off_lane[IDX_P11] = {6'h00, dac_en_in};
    off_lane[IDX_P4][DBG_DATA_BIT] = tool_conn_in;
    off_lane[IDX_P4][DBG_CLK_BIT] = tool_conn_in & dbg_two_line_in;
    pu_blk_lane[IDX_P4] = {8{tool_conn_in}} & PIN_MASK[IDX_P4];
  end

  // final pads: debug unit takes its pins over
  always_comb begin
    pad_out = slice_pad;
    if (tool_conn_in) begin
      pad_out[IDX_P4].out[DBG_DATA_BIT] = dbg_data_out_in & dbg_data_oe_in;
      pad_out[IDX_P4].oe[DBG_DATA_BIT]  = dbg_data_oe_in;
      if (dbg_two_line_in) begin
        pad_out[IDX_P4].out[DBG_CLK_BIT] = dbg_clk_in;
        pad_out[IDX_P4].oe[DBG_CLK_BIT]  = 1'b1;
      end
    end
  end

  assign dbg_data_in_out = pin_sync[IDX_P4][DBG_DATA_BIT];

  // odsel, analog config, amplifier enables, channel select
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      odsel_ff <= ODSEL_RST;
      ancfg_ff <= ANCFG_RST;
      opamp_ff <= OPAMP_RST;
      chsel_ff <= CHSEL_RST;
    end else if (wr_in) begin
      if (wdec.kind == KIND_ODSEL) odsel_ff <= merge(odsel_ff, wdata_in, wmask_in) & ODSEL_MASK;
      if (wdec.kind == KIND_ANCFG) ancfg_ff <= merge(ancfg_ff, wdata_in, wmask_in);
      if (addr_in == OFS_OPAMP) opamp_ff <= opamp_wr[2:0];
      if (addr_in == OFS_CHSEL) chsel_ff <= chsel_wr[2:0];
    end
  end

  // analog side: inputs in analog mode, amplifier outputs, conversion pick
  assign p2_analog = ancfg_ff & dir_ff[IDX_P2];
  always_comb begin
    opamp_pins = 8'h00;
    opamp_pins[OPAMP_PIN0] = opamp_ff[0];
    opamp_pins[OPAMP_PIN1] = opamp_ff[1];
    opamp_pins[OPAMP_PIN2] = opamp_ff[2];
    analog_sel_out = p2_analog & ~opamp_pins;
    convert_sel_out = p2_analog & (8'h01 << chsel_ff);
    opamp_drive_out = {p2_analog[OPAMP_PIN2], p2_analog[OPAMP_PIN1],
                       p2_analog[OPAMP_PIN0]} & opamp_ff;
  end
  assign opamp_en_out = opamp_ff;

  // prohibited: enable in digital mode, or analog with output direction
  assign bad_event = |(opamp_pins & ~ancfg_ff) ||
                     |(ancfg_ff & ~dir_ff[IDX_P2]);

  // sticky flag, write 1 clears, a new event wins over the clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      badcfg_ff <= 1'b0;
    end else if (bad_event) begin
      badcfg_ff <= 1'b1;
    end else if (wr_in && wdec.kind == KIND_STAT && wmask_in[STAT_BADCFG]
                 && wdata_in[STAT_BADCFG]) begin
      badcfg_ff <= 1'b0;
    end
  end
  assign prohibited_out = badcfg_ff;

  // read mux, unmapped addresses return zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (rdec.kind)
      KIND_DATA:  nxt_rdata = rd_lane[rdec.idx];
      KIND_DIR:   nxt_rdata = dir_ff[rdec.idx];
      KIND_PU:    nxt_rdata = pu_ff[rdec.idx];
      KIND_ODSEL: nxt_rdata = odsel_ff;
      KIND_ANCFG: nxt_rdata = ancfg_ff;
      KIND_CTRL:  nxt_rdata = (addr_in == OFS_OPAMP) ? {5'h00, opamp_ff} : {5'h00, chsel_ff};
      KIND_STAT:  nxt_rdata = {5'h00, badcfg_ff, dbg_two_line_in, tool_conn_in};
      default:    nxt_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_in ? nxt_rdata : 8'h00;
    end
  end
  assign rdata_out = rdata_ff;

  // ---- checks ----
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic [NPORT*8-1:0] chk_oe;
  logic [NPORT*8-1:0] chk_in_mode;
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      chk_oe[i*8 +: 8]      = slice_pad[i].oe;
      chk_in_mode[i*8 +: 8] = dir_ff[i];
    end
  end

  a_input_no_drive: assert property ((chk_oe & chk_in_mode) == '0)
    else $error("port drives a pin set to input");
  a_reset_inputs: assert property ($past(rst_in) |-> chk_oe == '0 && data_ff == '0)
    else $error("port not idle in input mode after reset");
  a_p3_pullup: assert property (pu_ff[IDX_P3][0] && dir_ff[IDX_P3][0] |-> pad_out[IDX_P3].pu[0])
    else $error("third port pull-up missing");
  a_tool_no_pu: assert property (tool_conn_in |-> pad_out[IDX_P4].pu[1:0] == 2'h0)
    else $error("pull-up on tool pin");
  a_tool_data_pin: assert property (tool_conn_in |-> pad_out[IDX_P4].oe[0] == dbg_data_oe_in)
    else $error("tool data pin not owned by debugger");
  a_two_line_clk: assert property (tool_conn_in && dbg_two_line_in |->
      pad_out[IDX_P4].oe[1] && pad_out[IDX_P4].out[1] == dbg_clk_in)
    else $error("tool clock pin not driven");
  a_p6_open_drain: assert property (pad_out[IDX_P6].out == 8'h00 && pad_out[IDX_P6].pu == 8'h00)
    else $error("sixth port drives high or pulls up");
  a_p8_od_pin0: assert property (odsel_ff[0] && !dir_ff[IDX_P8][0] && !alt_in[IDX_P8].en[0]
      && data_ff[IDX_P8][0] |-> !pad_out[IDX_P8].oe[0])
    else $error("eighth port open-drain drives high");
  a_p11_no_pu: assert property (pad_out[IDX_P11].pu == 8'h00)
    else $error("eleventh port pull-up");
  a_write_effect: assert property (wr_in && addr_in == OFS_DIR + 8'h03 && wmask_in == 8'hFF
      ##1 !(wr_in && wdec.kind == KIND_DIR) |=> pad_out[IDX_P5].oe != 8'h00 || $past(wdata_in, 2) != 8'h00
      || alt_in[IDX_P5].en != 8'h00)
    else $error("direction write lost");
  a_read_latch: assert property (rd_in && addr_in == OFS_DATA + 8'h03 && dir_ff[IDX_P5] == 8'h00
      |=> rdata_out == $past(data_ff[IDX_P5]))
    else $error("output-mode read not from latch");
  a_alt_drive: assert property (alt_in[IDX_P3].en[0] && !dir_ff[IDX_P3][0]
      |-> pad_out[IDX_P3].out[0] == alt_in[IDX_P3].val[0])
    else $error("peripheral output not on pin");
  a_badcfg_sticky: assert property (bad_event |=> prohibited_out [*2])
    else $error("prohibited setting not flagged");
  a_opamp_drive: assert property (opamp_ff[0] && ancfg_ff[OPAMP_PIN0] && dir_ff[IDX_P2][OPAMP_PIN0]
      |-> opamp_drive_out[0] && !pad_out[IDX_P2].oe[OPAMP_PIN0])
    else $error("amplifier output not routed");

  c_tool_two_line: cover property (tool_conn_in && dbg_two_line_in);
  c_p8_open_drain: cover property (odsel_ff[2] && !dir_ff[IDX_P8][2]);
  c_convert_opamp: cover property (opamp_drive_out[1] && convert_sel_out[OPAMP_PIN1]);
  c_read_input: cover property (rd_in && rdec.kind == KIND_DATA ##1 rdata_out != 8'h00);

endmodule // mpg_gpio_bank

// ### src/mpg_pkg.sv
// mpg_pkg: shared constants, register map and carrier types of the gpio bank
// assumes an 8-bit register port with byte addresses and one system clock
package mpg_pkg;

  // ports in this bank, lane index order: p2 p3 p4 p5 p6 p8 p10 p11
  localparam int NPORT = 8;
  localparam logic [2:0] IDX_P2  = 3'h0;
  localparam logic [2:0] IDX_P3  = 3'h1;
  localparam logic [2:0] IDX_P4  = 3'h2;
  localparam logic [2:0] IDX_P5  = 3'h3;
  localparam logic [2:0] IDX_P6  = 3'h4;
  localparam logic [2:0] IDX_P8  = 3'h5;
  localparam logic [2:0] IDX_P10 = 3'h6;
  localparam logic [2:0] IDX_P11 = 3'h7;

  // register byte offsets; data/direction/pull-up banks are 8 deep
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_DIR   = 8'h08;
  localparam logic [7:0] OFS_PU    = 8'h10;
  localparam logic [7:0] OFS_ODSEL = 8'h18;
  localparam logic [7:0] OFS_ANCFG = 8'h19;
  localparam logic [7:0] OFS_OPAMP = 8'h1A;
  localparam logic [7:0] OFS_CHSEL = 8'h1B;
  localparam logic [7:0] OFS_STAT  = 8'h1C;

  // reset values
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'hFF;
  localparam logic [7:0] PU_RST    = 8'h00;
  localparam logic [7:0] ODSEL_RST = 8'h00;
  localparam logic [7:0] ANCFG_RST = 8'h00;
  localparam logic [2:0] OPAMP_RST = 3'h0;
  localparam logic [2:0] CHSEL_RST = 3'h0;

  // capability masks per lane, lane 7 (p11) first
  localparam logic [NPORT-1:0][7:0] PIN_MASK =
    {8'h03, 8'h01, 8'h07, 8'h03, 8'hFF, 8'h03, 8'h1F, 8'hFF};
  localparam logic [NPORT-1:0][7:0] PU_MASK =
    {8'h00, 8'h01, 8'h07, 8'h00, 8'hFF, 8'h03, 8'h1F, 8'h00};
  localparam logic [NPORT-1:0][7:0] OD_FORCE =
    {8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ODSEL_MASK = 8'h05;   // p8 pins 0 and 2 only

  // field positions
  localparam int OPAMP_PIN0   = 1;   // amplifier outputs on p2 pins 1, 4, 7
  localparam int OPAMP_PIN1   = 4;
  localparam int OPAMP_PIN2   = 7;
  localparam int DBG_DATA_BIT = 0;
  localparam int DBG_CLK_BIT  = 1;
  localparam int STAT_TOOL    = 0;
  localparam int STAT_TWOLINE = 1;
  localparam int STAT_BADCFG  = 2;

  // register kinds produced by the address decoder
  typedef enum logic [7:0] {
    KIND_NONE  = 8'h01,
    KIND_DATA  = 8'h02,
    KIND_DIR   = 8'h04,
    KIND_PU    = 8'h08,
    KIND_ODSEL = 8'h10,
    KIND_ANCFG = 8'h20,
    KIND_CTRL  = 8'h40,
    KIND_STAT  = 8'h80
  } mpg_kind_t;

  typedef struct packed {
    mpg_kind_t  kind;
    logic [2:0] idx;
  } mpg_dec_t;

  // pad drive of one port: level, enable (high = driving), pull-up on
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } mpg_pad_t;

  // alternate peripheral output of one port
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] val;
  } mpg_alt_t;

  // address decode shared by the write and read paths
  function automatic mpg_dec_t mpg_decode(input logic [7:0] a);
    mpg_dec_t d;
    d.kind = KIND_NONE;
    d.idx  = a[2:0];
    if (a[7:3] == OFS_DATA[7:3]) d.kind = KIND_DATA;
    else if (a[7:3] == OFS_DIR[7:3]) d.kind = KIND_DIR;
    else if (a[7:3] == OFS_PU[7:3] && PU_MASK[a[2:0]] != 8'h00) d.kind = KIND_PU;
    else if (a == OFS_ODSEL) d.kind = KIND_ODSEL;
    else if (a == OFS_ANCFG) d.kind = KIND_ANCFG;
    else if (a == OFS_OPAMP || a == OFS_CHSEL) d.kind = KIND_CTRL;
    else if (a == OFS_STAT) d.kind = KIND_STAT;
    return d;
  endfunction

endpackage

// ### src/mpg_port_slice.sv
// mpg_port_slice: pad drive and read-back for one 8-bit port lane
// assumes register state and synchronised pin levels from the bank top
`timescale 1ns/1ps
module mpg_port_slice
  import mpg_pkg::*;
(
  // register state
  input  wire logic [7:0] latch_in,
  input  wire logic [7:0] dir_in,
  input  wire logic [7:0] pu_sel_in,
  input  wire logic [7:0] od_in,
  // capability and overrides
  input  wire logic [7:0] pin_mask_in,
  input  wire logic [7:0] pu_cap_in,
  input  wire logic [7:0] off_in,
  input  wire logic [7:0] pu_block_in,
  input  wire mpg_alt_t   alt_in,
  input  wire logic [7:0] pin_sync_in,
  // results
  output mpg_pad_t        pad_out,
  output logic [7:0]      rd_out
);

  logic [7:0] drv_val;
  logic [7:0] out_mode;

  // peripheral output replaces the latch when enabled
  assign drv_val  = (alt_in.en & alt_in.val) | (~alt_in.en & latch_in);
  // dir bit 0 turns the output buffer on
  assign out_mode = pin_mask_in & ~dir_in & ~off_in;

  // open drain pulls low only, push-pull drives both levels
  assign pad_out.oe  = out_mode & (~od_in | ~drv_val);
  assign pad_out.out = out_mode & ~od_in & drv_val;
  assign pad_out.pu  = pin_mask_in & pu_cap_in & pu_sel_in & dir_in & ~off_in & ~pu_block_in;

  // pin level in input mode, latch in output mode, zero when taken away
  assign rd_out = pin_mask_in & ~off_in & ((dir_in & pin_sync_in) | (~dir_in & latch_in));

endmodule // mpg_port_slice

// ### src/mpg_sync2.sv
// mpg_sync2: two-flop synchroniser for pad levels
// assumes inputs come from pins outside the clock domain
`timescale 1ns/1ps
module mpg_sync2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // levels
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end

  assign q_out = q_ff;

endmodule // mpg_sync2
